// *** hw/uart_channel_regs_defines.vh ***
// Offsets, field positions, reset values and select codes of one UART channel register map
`ifndef UART_CHANNEL_REGS_DEFINES_VH
`define UART_CHANNEL_REGS_DEFINES_VH

// Register offsets on the register port
`define OFF_HOLD 4'h0
`define OFF_IER 4'h1
`define OFF_IIR_FCR 4'h2
`define OFF_LCR 4'h3
`define OFF_MCR 4'h4
`define OFF_LSR 4'h5
`define OFF_MSR_TCR 4'h6
`define OFF_SPR_TLR 4'h7
`define OFF_TRANSMIT_FILL_LEVEL 4'h8
`define OFF_RECEIVE_FILL_LEVEL 4'h9

// Line control value that opens the enhanced bank
`define ENH_KEY 8'hBF

// Field positions
`define LCR_DIV_BIT 7
`define EFR_ENH_BIT 4
`define MCR_BANK_BIT 2
`define FCR_TXRST_BIT 2
`define FCR_RXRST_BIT 1
`define FCR_FEN_BIT 0

// Bits that change only with enhanced functions on
`define IER_ENH_MASK 8'hF0
`define FCR_ENH_MASK 8'h30
`define MCR_ENH_MASK 8'hE4

// Bits that are kept in storage (others read zero)
`define FCR_KEEP_MASK 8'hF1
`define MCR_KEEP_MASK 8'hF7

// Reset values
`define RST_IER 8'h00
`define RST_FCR 8'h00
`define RST_LCR 8'h00
`define RST_MCR 8'h00
`define RST_SPR 8'h00
`define RST_TCR 8'h00
`define RST_TLR 8'h00
`define RST_DIV 8'h00
`define RST_EFR 8'h00
`define RST_FLOW 8'h00

// Register select codes from the bank decoder
`define SEL_NONE 5'h00
`define SEL_HOLD 5'h01
`define SEL_IER 5'h02
`define SEL_IIR_FCR 5'h03
`define SEL_LCR 5'h04
`define SEL_MCR 5'h05
`define SEL_LSR 5'h06
`define SEL_MSR 5'h07
`define SEL_SPR 5'h08
`define SEL_TCR 5'h09
`define SEL_TLR 5'h0A
`define SEL_TRANSMIT_FILL_LEVEL 5'h0B
`define SEL_RECEIVE_FILL_LEVEL 5'h0C
`define SEL_DLL 5'h0D
`define SEL_DLH 5'h0E
`define SEL_EFR 5'h0F
`define SEL_RESUME_CHAR_ONE 5'h10
`define SEL_RESUME_CHAR_TWO 5'h11
`define SEL_PAUSE_CHAR_ONE 5'h12
`define SEL_PAUSE_CHAR_TWO 5'h13

`endif

// *** hw/bank_select.v ***
// Bank decoder: maps offset and bank state to one register select code
`default_nettype none
`include "uart_channel_regs_defines.vh"

module bank_select (
  input wire [3:0] addr_i,
  input wire [7:0] line_control_i,
  input wire enh_on_i,
  input wire bank_on_i,
  output reg [4:0] sel_o
);

  // Line control holds the enhanced key
  wire enh_key;
  // Divisor bytes visible
  wire div_open;
  // Transmission control and trigger level visible
  wire tcr_open;

  assign enh_key = (line_control_i == `ENH_KEY);
  assign div_open = line_control_i[`LCR_DIV_BIT] & ~enh_key;
  assign tcr_open = enh_on_i & bank_on_i;

  // Offset decode per bank
  always @* begin
    case (addr_i)
      `OFF_HOLD: sel_o = div_open ? `SEL_DLL : `SEL_HOLD;
      `OFF_IER: sel_o = div_open ? `SEL_DLH : `SEL_IER;
      `OFF_IIR_FCR: sel_o = enh_key ? `SEL_EFR : `SEL_IIR_FCR;
      `OFF_LCR: sel_o = `SEL_LCR;
      `OFF_MCR: sel_o = enh_key ? `SEL_RESUME_CHAR_ONE : `SEL_MCR;
      `OFF_LSR: sel_o = enh_key ? `SEL_RESUME_CHAR_TWO : `SEL_LSR;
      `OFF_MSR_TCR: begin
        if (enh_key) begin
          sel_o = `SEL_PAUSE_CHAR_ONE;
        end else begin
          sel_o = tcr_open ? `SEL_TCR : `SEL_MSR;
        end
      end
      `OFF_SPR_TLR: begin
        if (enh_key) begin
          sel_o = `SEL_PAUSE_CHAR_TWO;
        end else begin
          sel_o = tcr_open ? `SEL_TLR : `SEL_SPR;
        end
      end
      `OFF_TRANSMIT_FILL_LEVEL: sel_o = `SEL_TRANSMIT_FILL_LEVEL;
      `OFF_RECEIVE_FILL_LEVEL: sel_o = `SEL_RECEIVE_FILL_LEVEL;
      default: sel_o = `SEL_NONE;
    endcase
  end

endmodule // bank_select
`default_nettype wire

// *** hw/uart_channel_register_map.v ***
// Register map of one UART channel: bank switching, field storage and read mux
`default_nettype none
`include "uart_channel_regs_defines.vh"

module uart_channel_register_map (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire [3:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire [7:0] rx_data_i,
  input wire [5:0] int_id_i,
  input wire [7:0] line_status_i,
  input wire [7:0] modem_status_i,
  input wire [7:0] tx_fill_i,
  input wire [7:0] rx_fill_i,
  output reg [7:0] tx_data_o,
  output reg tx_push_o,
  output reg rx_pop_o,
  output reg tx_fifo_reset_o,
  output reg rx_fifo_reset_o,
  output reg iir_read_o,
  output reg [7:0] interrupt_enable_o,
  output reg [7:0] fifo_control_o,
  output reg [7:0] line_control_o,
  output reg [7:0] modem_control_o,
  output reg [15:0] divisor_o,
  output reg [7:0] enhanced_feature_register_o,
  output reg [7:0] resume_char_one_o,
  output reg [7:0] resume_char_two_o,
  output reg [7:0] pause_char_one_o,
  output reg [7:0] pause_char_two_o,
  output reg [7:0] transmission_control_o,
  output reg [7:0] trigger_level_o
);

  ////////////////////////////////////////////////////////////////////////
  // Helper functions
  ////////////////////////////////////////////////////////////////////////

  // Keep locked bits, take the rest from the write
  function [7:0] merge;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] lock;
    begin
      merge = (old_val & lock) | (new_val & ~lock);
    end
  endfunction

  // Lock mask: enhanced-only bits frozen while enhanced is off
  function [7:0] lock_of;
    input enh;
    input [7:0] enh_mask;
    begin
      lock_of = enh ? 8'h00 : enh_mask;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Internal state
  ////////////////////////////////////////////////////////////////////////

  // Scratch storage, no effect on the channel
  reg [7:0] scratch_register;
  // Register select for the current access
  wire [4:0] sel;
  // Enhanced functions bit
  wire enh_on;
  // Bank enable bit of modem control
  wire bank_on;
  // FIFO enable as mirrored into identification
  wire fifo_on;
  // Next read data
  reg [7:0] next_rdata;

  assign enh_on = enhanced_feature_register_o[`EFR_ENH_BIT];
  assign bank_on = modem_control_o[`MCR_BANK_BIT];
  assign fifo_on = fifo_control_o[`FCR_FEN_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Bank decoder
  ////////////////////////////////////////////////////////////////////////

  // Bank state before this cycle's write picks the register
  bank_select u_bank_select (
    .addr_i(reg_addr_i),
    .line_control_i(line_control_o),
    .enh_on_i(enh_on),
    .bank_on_i(bank_on),
    .sel_o(sel)
  );

  ////////////////////////////////////////////////////////////////////////
  // Write path
  ////////////////////////////////////////////////////////////////////////

  // Register writes and write-side pulses
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_data_o <= 8'h00;
      tx_push_o <= 1'b0;
      tx_fifo_reset_o <= 1'b0;
      rx_fifo_reset_o <= 1'b0;
      interrupt_enable_o <= `RST_IER;
      fifo_control_o <= `RST_FCR;
      line_control_o <= `RST_LCR;
      modem_control_o <= `RST_MCR;
      scratch_register <= `RST_SPR;
      transmission_control_o <= `RST_TCR;
      trigger_level_o <= `RST_TLR;
      divisor_o <= {`RST_DIV, `RST_DIV};
      enhanced_feature_register_o <= `RST_EFR;
      resume_char_one_o <= `RST_FLOW;
      resume_char_two_o <= `RST_FLOW;
      pause_char_one_o <= `RST_FLOW;
      pause_char_two_o <= `RST_FLOW;
    end else begin
      // Pulses last one cycle
      tx_push_o <= 1'b0;
      tx_fifo_reset_o <= 1'b0;
      rx_fifo_reset_o <= 1'b0;
      if (reg_wr_i) begin
        case (sel)
          // Next character to transmit
          `SEL_HOLD: begin
            tx_data_o <= reg_wdata_i;
            tx_push_o <= 1'b1;
          end
          // Interrupt enables, top nibble enhanced-only
          `SEL_IER: begin
            interrupt_enable_o <= merge(interrupt_enable_o, reg_wdata_i,
              lock_of(enh_on, `IER_ENH_MASK));
          end
          // FIFO control; reset bits only pulse
          `SEL_IIR_FCR: begin
            fifo_control_o <= merge(fifo_control_o,
              reg_wdata_i & `FCR_KEEP_MASK,
              lock_of(enh_on, `FCR_ENH_MASK));
            tx_fifo_reset_o <= reg_wdata_i[`FCR_TXRST_BIT];
            rx_fifo_reset_o <= reg_wdata_i[`FCR_RXRST_BIT];
          end
          // Line control, all bits writable
          `SEL_LCR: begin
            line_control_o <= reg_wdata_i;
          end
          // Modem control, upper bits and bank bit enhanced-only
          `SEL_MCR: begin
            modem_control_o <= merge(modem_control_o,
              reg_wdata_i & `MCR_KEEP_MASK,
              lock_of(enh_on, `MCR_ENH_MASK));
          end
          // Scratch storage
          `SEL_SPR: begin
            scratch_register <= reg_wdata_i;
          end
          // Transmission control
          `SEL_TCR: begin
            transmission_control_o <= reg_wdata_i;
          end
          // Trigger level
          `SEL_TLR: begin
            trigger_level_o <= reg_wdata_i;
          end
          // Divisor low byte
          `SEL_DLL: begin
            divisor_o[7:0] <= reg_wdata_i;
          end
          // Divisor high byte
          `SEL_DLH: begin
            divisor_o[15:8] <= reg_wdata_i;
          end
          // Enhanced feature register
          `SEL_EFR: begin
            enhanced_feature_register_o <= reg_wdata_i;
          end
          // Flow control characters
          `SEL_RESUME_CHAR_ONE: begin
            resume_char_one_o <= reg_wdata_i;
          end
          `SEL_RESUME_CHAR_TWO: begin
            resume_char_two_o <= reg_wdata_i;
          end
          `SEL_PAUSE_CHAR_ONE: begin
            pause_char_one_o <= reg_wdata_i;
          end
          `SEL_PAUSE_CHAR_TWO: begin
            pause_char_two_o <= reg_wdata_i;
          end
          // Status and level registers ignore writes
          `SEL_LSR, `SEL_MSR, `SEL_TRANSMIT_FILL_LEVEL, `SEL_RECEIVE_FILL_LEVEL: begin
            tx_push_o <= 1'b0;
          end
          // Unmapped offsets ignore writes
          default: begin
            tx_push_o <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  ////////////////////////////////////////////////////////////////////////

  // Read data for the selected register
  always @* begin
    case (sel)
      // Oldest received character
      `SEL_HOLD: next_rdata = rx_data_i;
      // Interrupt enables
      `SEL_IER: next_rdata = interrupt_enable_o;
      // Identification: FIFO enable twice, priority, status
      `SEL_IIR_FCR: next_rdata = {fifo_on, fifo_on, int_id_i};
      // Line control
      `SEL_LCR: next_rdata = line_control_o;
      // Modem control, reserved bit already zero
      `SEL_MCR: next_rdata = modem_control_o;
      // Line status from the channel
      `SEL_LSR: next_rdata = line_status_i;
      // Modem status from the channel
      `SEL_MSR: next_rdata = modem_status_i;
      // Scratch readback
      `SEL_SPR: next_rdata = scratch_register;
      // Enhanced bank-two registers
      `SEL_TCR: next_rdata = transmission_control_o;
      `SEL_TLR: next_rdata = trigger_level_o;
      // FIFO fill levels
      `SEL_TRANSMIT_FILL_LEVEL: next_rdata = tx_fill_i;
      `SEL_RECEIVE_FILL_LEVEL: next_rdata = rx_fill_i;
      // Divisor bytes
      `SEL_DLL: next_rdata = divisor_o[7:0];
      `SEL_DLH: next_rdata = divisor_o[15:8];
      // Enhanced bank
      `SEL_EFR: next_rdata = enhanced_feature_register_o;
      `SEL_RESUME_CHAR_ONE: next_rdata = resume_char_one_o;
      `SEL_RESUME_CHAR_TWO: next_rdata = resume_char_two_o;
      `SEL_PAUSE_CHAR_ONE: next_rdata = pause_char_one_o;
      `SEL_PAUSE_CHAR_TWO: next_rdata = pause_char_two_o;
      // Unmapped offsets read zero
      default: next_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path
  ////////////////////////////////////////////////////////////////////////

  // Read data capture and read-side pulses
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
      rx_pop_o <= 1'b0;
      iir_read_o <= 1'b0;
    end else begin
      // Pop the receive FIFO only on a holding read
      rx_pop_o <= reg_rd_i & (sel == `SEL_HOLD);
      // Identification read, lets the channel clear events
      iir_read_o <= reg_rd_i & (sel == `SEL_IIR_FCR);
      // Data stands until the next read
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

endmodule // uart_channel_register_map
`default_nettype wire

// *** bench/uart_map_properties.sv ***
// Concurrent checks on the register port of one UART channel map
`default_nettype none
`include "uart_channel_regs_defines.vh"
module uart_map_properties (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] rx_data_i,
  input wire logic [5:0] int_id_i,
  input wire logic [7:0] line_status_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_push_o,
  input wire logic rx_pop_o,
  input wire logic tx_fifo_reset_o,
  input wire logic iir_read_o,
  input wire logic [7:0] interrupt_enable_o,
  input wire logic [7:0] fifo_control_o,
  input wire logic [7:0] line_control_o,
  input wire logic [7:0] modem_control_o,
  input wire logic [15:0] divisor_o,
  input wire logic [7:0] enhanced_feature_register_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  // Bank state as it stood before the taking edge
  wire logic key = line_control_o == `ENH_KEY;
  wire logic div = line_control_o[7] && !key;
  wire logic enh = enhanced_feature_register_o[4];
  // One-cycle strobe
  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_hold_write: assert property (reg_wr_i && reg_addr_i == `OFF_HOLD && !div |=>
    tx_push_o && tx_data_o == $past(reg_wdata_i)) else $error("transmit write lost");
  a_hold_read: assert property (reg_rd_i && reg_addr_i == `OFF_HOLD && !div |=>
    rx_pop_o && reg_rdata_o == $past(rx_data_i)) else $error("receive read wrong");
  a_iir_layout: assert property (reg_rd_i && reg_addr_i == `OFF_IIR_FCR && !key |=> iir_read_o &&
    reg_rdata_o == {{2{$past(fifo_control_o[0])}}, $past(int_id_i)}) else $error("id read wrong");
  a_fifo_reset: assert property (reg_wr_i && reg_addr_i == `OFF_IIR_FCR && !key && reg_wdata_i[2]
    |=> s_pulse(tx_fifo_reset_o)) else $error("tx reset pulse wrong");
  a_divisor_low: assert property (reg_wr_i && reg_addr_i == `OFF_HOLD && div |=>
    divisor_o[7:0] == $past(reg_wdata_i) && !tx_push_o) else $error("divisor low wrong");
  a_key_bank: assert property (reg_wr_i && reg_addr_i == `OFF_IIR_FCR && key |=>
    enhanced_feature_register_o == $past(reg_wdata_i) && !tx_fifo_reset_o) else $error("key bank wrong");
  a_prescaler_lock: assert property (reg_wr_i && reg_addr_i == `OFF_MCR && !key && !enh |=>
    $stable(modem_control_o[7:5]) && $stable(modem_control_o[2])) else $error("locked modem bits moved");
  a_ier_lock: assert property (reg_wr_i && reg_addr_i == `OFF_IER && !div && !enh |=>
    $stable(interrupt_enable_o[7:4]) && interrupt_enable_o[3:0] == $past(reg_wdata_i[3:0]))
    else $error("enable bits wrong");
  a_status_read: assert property (reg_rd_i && reg_addr_i == `OFF_LSR && !key |=>
    reg_rdata_o == $past(line_status_i)) else $error("line status read wrong");
  a_reserved_zero: assert property (modem_control_o[3] == 1'b0 && fifo_control_o[3:1] == 3'h0)
    else $error("reserved bit set");
endmodule // uart_map_properties
bind uart_channel_register_map uart_map_properties i_uart_map_properties (.clk_sys_i, .nrst_i,
  .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .rx_data_i, .int_id_i, .line_status_i,
  .tx_data_o, .tx_push_o, .rx_pop_o, .tx_fifo_reset_o, .iir_read_o, .interrupt_enable_o, .fifo_control_o,
  .line_control_o, .modem_control_o, .divisor_o, .enhanced_feature_register_o);
`default_nettype wire

// *** bench/uart_channel_model.sv ***
// Channel side model: receive queue head and status values
`default_nettype none
module uart_channel_model #(
  parameter logic [7:0] RX_FIRST = 8'h40,
  parameter logic [5:0] ID = 6'h0C,
  parameter logic [7:0] LS = 8'h61,
  parameter logic [7:0] MS = 8'hB0,
  parameter logic [7:0] TXF = 8'h3F,
  parameter logic [7:0] RXF = 8'h05
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic rx_pop_i,
  output logic [7:0] rx_data_o,
  output logic [5:0] int_id_o,
  output logic [7:0] line_status_o,
  output logic [7:0] modem_status_o,
  output logic [7:0] tx_fill_o,
  output logic [7:0] rx_fill_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Head of queue moves on to the next character after each pop
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_data_o <= RX_FIRST;
    end else if (rx_pop_i) begin
      rx_data_o <= rx_data_o + 8'h01;
    end
  end
  // Fixed status seen by the host
  assign int_id_o = ID;
  assign line_status_o = LS;
  assign modem_status_o = MS;
  assign tx_fill_o = TXF;
  assign rx_fill_o = RXF;
endmodule // uart_channel_model
`default_nettype wire

// *** bench/uart_channel_register_map_test.sv ***
// Self-checking bench of the UART channel register map
`default_nettype none
module uart_channel_register_map_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] LS = 8'h61, MS = 8'hB0, TXF = 8'h3F, RXF = 8'h05;
  localparam logic [5:0] ID = 6'h0C;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00, r;
  int failures = 0, total_checks = 0;
  wire logic [7:0] reg_rdata_o, rx_data_i, line_status_i, modem_status_i, tx_fill_i, rx_fill_i, tx_data_o;
  wire logic [7:0] interrupt_enable_o, fifo_control_o, line_control_o, modem_control_o;
  wire logic [7:0] enhanced_feature_register_o, transmission_control_o, trigger_level_o;
  wire logic [5:0] int_id_i;
  wire logic [15:0] divisor_o;
  wire logic tx_push_o, rx_pop_o, tx_fifo_reset_o, rx_fifo_reset_o, iir_read_o;
  always #2 clk_sys_i = ~clk_sys_i;
  uart_channel_register_map i_uart_channel_register_map (.clk_sys_i, .nrst_i, .reg_addr_i, .reg_wr_i,
    .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .rx_data_i, .int_id_i, .line_status_i, .modem_status_i,
    .tx_fill_i, .rx_fill_i, .tx_data_o, .tx_push_o, .rx_pop_o, .tx_fifo_reset_o, .rx_fifo_reset_o,
    .iir_read_o, .interrupt_enable_o, .fifo_control_o, .line_control_o, .modem_control_o, .divisor_o,
    .enhanced_feature_register_o, .resume_char_one_o(), .resume_char_two_o(), .pause_char_one_o(),
    .pause_char_two_o(), .transmission_control_o, .trigger_level_o);
  uart_channel_model #(.ID(ID), .LS(LS), .MS(MS), .TXF(TXF), .RXF(RXF)) i_uart_channel_model (
    .clk_sys_i, .nrst_i, .rx_pop_i(rx_pop_o), .rx_data_o(rx_data_i), .int_id_o(int_id_i),
    .line_status_o(line_status_i), .modem_status_o(modem_status_i), .tx_fill_o(tx_fill_i),
    .rx_fill_o(rx_fill_i));
  ////////////////////////////////////////////////////////////////////////
  // Bus cycles, driven on the falling edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    rd(a, r);
    chk(r, e);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_hold;
    wr(4'h0, 8'h5A);
    chk(tx_data_o, 8'h5A);
    chk({7'h00, tx_push_o}, 8'h01);
    rchk(4'h0, 8'h40);
    chk({7'h00, rx_pop_o}, 8'h01);
    rchk(4'h0, 8'h41);
  endtask
  task automatic t_readonly;
    for (int i = 5; i < 11; i++) wr(4'(i), 8'hFF);
    wr(4'h7, 8'hC3);
    rchk(4'h5, LS);
    rchk(4'h6, MS);
    rchk(4'h8, TXF);
    rchk(4'h9, RXF);
    rchk(4'h7, 8'hC3);
    rchk(4'hA, 8'h00);
  endtask
  task automatic t_lock;
    wr(4'h1, 8'hFF);
    rchk(4'h1, 8'h0F);
    wr(4'h4, 8'hFF);
    rchk(4'h4, 8'h13);
    wr(4'h2, 8'hF7);
    chk({6'h00, tx_fifo_reset_o, rx_fifo_reset_o}, 8'h03);
    chk(fifo_control_o, 8'hC1);
    repeat (2) @(negedge clk_sys_i);
    rchk(4'h2, {2'b11, ID});
  endtask
  task automatic t_divisor;
    wr(4'h3, 8'h83);
    wr(4'h0, 8'h34);
    wr(4'h1, 8'h12);
    chk(divisor_o[15:8], 8'h12);
    chk(divisor_o[7:0], 8'h34);
    chk(tx_data_o, 8'h5A);
    rchk(4'h0, 8'h34);
    rchk(4'h1, 8'h12);
    chk({7'h00, rx_pop_o}, 8'h00);
    rchk(4'h3, 8'h83);
  endtask
  task automatic t_key;
    wr(4'h3, 8'hBF);
    wr(4'h0, 8'h77);
    chk(divisor_o[7:0], 8'h34);
    wr(4'h2, 8'h10);
    for (int i = 4; i < 8; i++) wr(4'(i), 8'hA0 + 8'(i));
    for (int i = 4; i < 8; i++) rchk(4'(i), 8'hA0 + 8'(i));
    rchk(4'h2, 8'h10);
  endtask
  task automatic t_enhanced;
    wr(4'h3, 8'h03);
    wr(4'h1, 8'hFF);
    rchk(4'h1, 8'hFF);
    wr(4'h4, 8'hFF);
    rchk(4'h4, 8'hF7);
    wr(4'h6, 8'h66);
    wr(4'h7, 8'h99);
    chk(transmission_control_o, 8'h66);
    chk(trigger_level_o, 8'h99);
    rchk(4'h6, 8'h66);
    rchk(4'h7, 8'h99);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence after a four-cycle reset
  initial begin
    repeat (4) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    rchk(4'h3, 8'h00);
    rchk(4'h1, 8'h00);
    t_hold();
    t_readonly();
    t_lock();
    t_divisor();
    t_key();
    t_enhanced();
    print_verdict();
  end
  // Watchdog well past the expected run
  initial begin
    #20000;
    failures++;
    print_verdict();
  end
endmodule // uart_channel_register_map_test
`default_nettype wire
